// ---- src/hbp_consts.svh ----
// offsets, field positions, reset values and timing counts of the h-bridge pwm timer
//
// Overview of operation
// R1 - eight 9-bit channels, each on a pin pair; 0-3 first port, 4-7 second
// R2 - prescale 00 = 2E, 01 = E, 10 = E/2, 11 = E/4 channel clock
// R3 - shared counter advances per channel clock, wraps from 0x1ff to zero
// R4 - duty match sets channel flip-flop; counter wrap resets it
// R5 - polarity one starts high, low at match; zero starts low, high at match
// R6 - polarity change reaches the output at once, no wait for wrap
// R7 - duty written while enabled is buffered until wrap or channel disable
// R8 - duty write followed by counter write makes the buffered duty active at once
// R9 - any counter write clears the counter, even while channels run
// R10 - reading the counter disturbs neither the count nor any channel
// R11 - upper byte read latches lower byte for one following read
// R12 - with 2E channel clock the counter lsb reads back zero
// R13 - enable zero gives general-purpose pins; one routes the waveform
// R14 - duty sign picks which pin carries the waveform; other pin drives gpio value
// R15 - duty is two's complement -512..+511; sign set inverts the waveform
// R16 - duty -1 to 0 flips polarity and swaps waveform and gpio pins
// R17 - hardware sets interrupt flag; software writes one to bit 1 to clear
// R18 - mask bit 0 gates the interrupt request
// R19 - unused clock control bits 7,6,3,2 read zero
// R20 - six-bit counter extension; its overflow sets the flag; counter write clears it
// R21 - duty zero holds output high at polarity zero, low at polarity one
// R22 - duty register holds 9-bit magnitude plus sign, reads back last write
// R23 - interrupt request is flag AND mask, held until flag is cleared
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

`define HBP_NUM_CH 8
`define HBP_ADDR_CLK 8'h78
`define HBP_ADDR_EN 8'h79
`define HBP_ADDR_POL 8'h7a
`define HBP_ADDR_CNT_HI 8'h7b
`define HBP_ADDR_CNT_LO 8'h7c
`define HBP_DUTY_PAGE 4'h6
`define HBP_CLK_RST 8'h00
`define HBP_EN_RST 8'h00
`define HBP_POL_RST 8'h00
`define HBP_DUTY_RST 10'h3ff
`define HBP_CNT_MAX 9'h1ff
`define HBP_EXT_MAX 6'h3f
`define HBP_FLD_MASK 0
`define HBP_FLD_FLAG 1
`define HBP_FLD_PRESC_LO 4
`define HBP_FLD_PRESC_HI 5
`define HBP_FLD_SIGN 9
`define HBP_DIV_W 3

`endif

// ---- src/hbp_pkg.sv ----
// types shared by the h-bridge pwm timer modules
`default_nettype none
package hbp_pkg;
  typedef logic [9:0] hbp_duty_t;
  typedef logic [8:0] hbp_count_t;
  typedef enum logic [1:0] {
    HBP_PRESC_2E = 2'h0,
    HBP_PRESC_E = 2'h1,
    HBP_PRESC_E2 = 2'h2,
    HBP_PRESC_E4 = 2'h3
  } hbp_presc_e;
endpackage
`default_nettype wire

// ---- src/hbp_chan_if.sv ----
// carrier between the timer core and one channel
`timescale 1ns/1ps
`default_nettype none
interface hbp_chan_if;
  logic cnt_evt;
  hbp_pkg::hbp_count_t cnt_next;
  logic wrap;
  logic force_load;
  logic enable;
  logic polarity;
  hbp_pkg::hbp_duty_t duty_buf;
  logic gpio_left;
  logic gpio_right;
  logic pin_left;
  logic pin_right;
  modport core (output cnt_evt, cnt_next, wrap, force_load, enable, polarity, duty_buf,
                gpio_left, gpio_right, input pin_left, pin_right);
  modport chan (input cnt_evt, cnt_next, wrap, force_load, enable, polarity, duty_buf,
                gpio_left, gpio_right, output pin_left, pin_right);
endinterface
`default_nettype wire

// ---- src/hbp_channel.sv ----
// one pwm channel: active duty, output flip-flop and pin pair steering
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.svh"
module hbp_channel (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // link to the core
  hbp_chan_if.chan ch
);
  hbp_pkg::hbp_duty_t active_reg;
  hbp_pkg::hbp_duty_t duty_eff;
  logic ff_reg;
  logic sign;
  logic wave;

  // buffer passes through while disabled, else only at wrap or counter write
  assign duty_eff = (!ch.enable || ch.wrap || ch.force_load) ? ch.duty_buf : active_reg; // [R7] [R8]
  assign sign = duty_eff[`HBP_FLD_SIGN];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active_reg <= `HBP_DUTY_RST;
    end else begin
      active_reg <= duty_eff; // [R7]
    end
  end

  // match beats wrap so a zero duty never leaves the changed state
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ff_reg <= 1'b0;
    end else if (ch.cnt_evt) begin
      if (ch.cnt_next == duty_eff[8:0]) begin
        ff_reg <= 1'b1; // [R4] [R21]
      end else if (ch.cnt_next == 9'h000) begin
        ff_reg <= 1'b0; // [R4]
      end
    end
  end

  // polarity is combinational on the flip-flop, so it acts at once
  assign wave = (ch.polarity ? ~ff_reg : ff_reg) ^ sign; // [R5] [R6] [R15] [R16]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ch.pin_left <= 1'b0;
      ch.pin_right <= 1'b0;
    end else if (!ch.enable) begin
      ch.pin_left <= ch.gpio_left; // [R13]
      ch.pin_right <= ch.gpio_right;
    end else begin
      ch.pin_left <= sign ? ch.gpio_left : wave; // [R14] [R16]
      ch.pin_right <= sign ? wave : ch.gpio_right;
    end
  end
endmodule
`default_nettype wire

// ---- src/hbp_pwm_timer.sv ----
// eight-channel h-bridge pwm timer with register port
`timescale 1ns/1ps
`default_nettype none
`include "hbp_consts.svh"
module hbp_pwm_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // general-purpose output values, one per pin
  input wire logic [7:0] first_port_gpio,
  input wire logic [7:0] second_port_gpio,
  // pin pairs, channel n on bits 2n and 2n+1 of the first port, channel n+4 on the same bits of the second port
  output logic [7:0] first_port_pin_pair,
  output logic [7:0] second_port_pin_pair,
  // interrupt request
  output logic pwm_irq
);
  localparam int NCH = `HBP_NUM_CH;

  // control state
  hbp_pkg::hbp_presc_e presc_reg;
  logic irq_flag_reg;
  logic irq_mask_reg;
  logic [NCH-1:0] enable_reg;
  logic [NCH-1:0] polarity_reg;
  hbp_pkg::hbp_duty_t duty_buf_reg [NCH];

  // counting state
  logic [`HBP_DIV_W-1:0] div_reg;
  hbp_pkg::hbp_count_t cnt_reg;
  hbp_pkg::hbp_count_t cnt_next;
  logic [5:0] ext_reg;
  logic [7:0] low_latch_reg;
  logic latch_valid_reg;

  // decoded strobes
  logic wr_clk;
  logic wr_en;
  logic wr_pol;
  logic wr_cnt;
  logic rd_cnt_hi;
  logic duty_hit;
  logic [2:0] duty_ch;
  logic duty_hi;
  logic tick;
  logic cnt_evt;
  logic wrap;
  logic ext_ovf;
  logic [`HBP_DIV_W-1:0] div_mask;

  // register decode
  assign wr_clk = reg_wr && (reg_addr == `HBP_ADDR_CLK);
  assign wr_en = reg_wr && (reg_addr == `HBP_ADDR_EN);
  assign wr_pol = reg_wr && (reg_addr == `HBP_ADDR_POL);
  assign wr_cnt = reg_wr && ((reg_addr == `HBP_ADDR_CNT_HI) || (reg_addr == `HBP_ADDR_CNT_LO)); // [R9]
  assign rd_cnt_hi = reg_rd && (reg_addr == `HBP_ADDR_CNT_HI);
  assign duty_hit = (reg_addr[7:4] == `HBP_DUTY_PAGE);
  assign duty_ch = reg_addr[3:1];
  assign duty_hi = ~reg_addr[0];

  // prescaler: one ref_clk per 2E period, so E is every second cycle
  always_comb begin
    unique case (presc_reg)
      hbp_pkg::HBP_PRESC_2E: div_mask = 3'h0;
      hbp_pkg::HBP_PRESC_E: div_mask = 3'h1;
      hbp_pkg::HBP_PRESC_E2: div_mask = 3'h3;
      hbp_pkg::HBP_PRESC_E4: div_mask = 3'h7;
    endcase
  end

  assign tick = ((div_reg & div_mask) == div_mask); // [R2]

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // shared counter; a write wins over a tick in the same cycle
  assign cnt_evt = tick || wr_cnt;
  assign wrap = tick && !wr_cnt && (cnt_reg == `HBP_CNT_MAX); // [R3]

  always_comb begin
    if (wr_cnt) begin
      cnt_next = 9'h000; // [R9]
    end else if (cnt_reg == `HBP_CNT_MAX) begin
      cnt_next = 9'h000; // [R3]
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= 9'h000;
    end else if (cnt_evt) begin
      cnt_reg <= cnt_next; // [R3] [R9]
    end
  end

  // extension counts periods; cleared with the counter to stay in phase
  assign ext_ovf = wrap && (ext_reg == `HBP_EXT_MAX);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_reg <= 6'h00;
    end else if (wr_cnt) begin
      ext_reg <= 6'h00; // [R20]
    end else if (wrap) begin
      ext_reg <= ext_reg + 6'h01; // [R20]
    end
  end

  // interrupt flag: a set in the clearing cycle is kept
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_flag_reg <= 1'b0;
    end else if (ext_ovf) begin
      irq_flag_reg <= 1'b1; // [R17] [R20]
    end else if (wr_clk && reg_wdata[`HBP_FLD_FLAG]) begin
      irq_flag_reg <= 1'b0; // [R17]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwm_irq <= 1'b0;
    end else begin
      pwm_irq <= irq_flag_reg && irq_mask_reg; // [R18] [R23]
    end
  end

  // clock control writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc_reg <= hbp_pkg::hbp_presc_e'(2'(`HBP_CLK_RST >> `HBP_FLD_PRESC_LO));
      irq_mask_reg <= 1'b0;
    end else if (wr_clk) begin
      presc_reg <= hbp_pkg::hbp_presc_e'(reg_wdata[`HBP_FLD_PRESC_HI:`HBP_FLD_PRESC_LO]); // [R2]
      irq_mask_reg <= reg_wdata[`HBP_FLD_MASK]; // [R18]
    end
  end

  // enable and polarity
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_reg <= `HBP_EN_RST;
    end else if (wr_en) begin
      enable_reg <= reg_wdata; // [R13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      polarity_reg <= `HBP_POL_RST;
    end else if (wr_pol) begin
      polarity_reg <= reg_wdata; // [R5] [R6]
    end
  end

  // duty buffers: high byte holds sign and bit 8, low byte bits 7..0
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < NCH; i++) begin
        duty_buf_reg[i] <= `HBP_DUTY_RST;
      end
    end else if (reg_wr && duty_hit) begin
      if (duty_hi) begin
        duty_buf_reg[duty_ch][9:8] <= reg_wdata[1:0]; // [R22] [R15]
      end else begin
        duty_buf_reg[duty_ch][7:0] <= reg_wdata; // [R22]
      end
    end
  end

  // upper-byte read freezes the lower byte for the next cycle only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      low_latch_reg <= 8'h00;
    end else if (rd_cnt_hi) begin
      low_latch_reg <= cnt_reg[7:0]; // [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_valid_reg <= 1'b0;
    end else begin
      latch_valid_reg <= rd_cnt_hi; // [R11]
    end
  end

  // read data, one cycle after the strobe; only the upper counter byte read has a side effect, latching the lower byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (duty_hit) begin
        reg_rdata <= duty_hi ? {6'h00, duty_buf_reg[duty_ch][9:8]} : duty_buf_reg[duty_ch][7:0]; // [R22]
      end else begin
        unique case (reg_addr)
          `HBP_ADDR_CLK: reg_rdata <= {2'h0, presc_reg, 2'h0, irq_flag_reg, irq_mask_reg}; // [R19]
          `HBP_ADDR_EN: reg_rdata <= enable_reg;
          `HBP_ADDR_POL: reg_rdata <= polarity_reg;
          `HBP_ADDR_CNT_HI: reg_rdata <= {7'h00, cnt_reg[8]}; // [R10]
          `HBP_ADDR_CNT_LO: begin
            // the lsb toggles faster than software can see at 2E
            reg_rdata <= (latch_valid_reg ? low_latch_reg : cnt_reg[7:0])
                         & {7'h7f, presc_reg != hbp_pkg::HBP_PRESC_2E}; // [R10] [R11] [R12]
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // channels: 0-3 on the first port, 4-7 on the second
  logic [2*NCH-1:0] gpio_all;
  logic [2*NCH-1:0] pins_all;
  assign gpio_all = {second_port_gpio, first_port_gpio};
  assign first_port_pin_pair = pins_all[7:0]; // [R1]
  assign second_port_pin_pair = pins_all[15:8]; // [R1]

  hbp_chan_if chan_link [NCH] ();

  generate
    for (genvar g = 0; g < NCH; g++) begin : gen_ch
      assign chan_link[g].cnt_evt = cnt_evt;
      assign chan_link[g].cnt_next = cnt_next;
      assign chan_link[g].wrap = wrap;
      assign chan_link[g].force_load = wr_cnt; // [R8]
      assign chan_link[g].enable = enable_reg[g];
      assign chan_link[g].polarity = polarity_reg[g];
      assign chan_link[g].duty_buf = duty_buf_reg[g];
      assign chan_link[g].gpio_left = gpio_all[2*g];
      assign chan_link[g].gpio_right = gpio_all[2*g+1];
      assign pins_all[2*g] = chan_link[g].pin_left;
      assign pins_all[2*g+1] = chan_link[g].pin_right;

      hbp_channel u_ch (
        .ref_clk(ref_clk),
        .srst(srst),
        .ch(chan_link[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ---- testbench/hbp_coil_model.sv ----
// coil driver model: current direction through each h-bridge
`timescale 1ns/1ps
`default_nettype none
module hbp_coil_model (
  // pins from the timer
  input wire logic [7:0] first_port_pin_pair,
  input wire logic [7:0] second_port_pin_pair,
  // per-coil current, left to right and right to left
  output logic [7:0] coil_fwd,
  output logic [7:0] coil_rev
);
  logic [15:0] pins;
  assign pins = {second_port_pin_pair, first_port_pin_pair};
  // equal levels on both pins leave the coil without current
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      coil_fwd[n] = pins[2*n] & ~pins[2*n+1];
      coil_rev[n] = ~pins[2*n] & pins[2*n+1];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/hbp_pwm_timer_asserts.sv ----
// checker for the pwm timer ports
`timescale 1ns/1ps
`default_nettype none
module hbp_pwm_timer_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and interrupt
  input wire logic [7:0] first_port_gpio,
  input wire logic [7:0] second_port_gpio,
  input wire logic [7:0] first_port_pin_pair,
  input wire logic [7:0] second_port_pin_pair,
  input wire logic pwm_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // shadows follow the same writes as the block
  logic [1:0] presc_reg;
  logic mask_reg;
  logic [7:0] en_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc_reg <= 2'h0;
      mask_reg <= 1'b0;
      en_reg <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h78) begin
      presc_reg <= reg_wdata[5:4];
      mask_reg <= reg_wdata[0];
    end else if (reg_wr && reg_addr == 8'h79) begin
      en_reg <= reg_wdata;
    end
  end
  a_unused_zero: assert property (reg_rd && reg_addr == 8'h78 |=> (reg_rdata & 8'hcc) == 8'h00)
    else $error("clock control unused bits set");
  a_cnt_clear: assert property (reg_wr && reg_addr == 8'h7c ##2 reg_rd && reg_addr == 8'h7c |=> reg_rdata < 8'h04)
    else $error("counter not cleared by write");
  a_lsb_zero: assert property (reg_rd && reg_addr == 8'h7c && presc_reg == 2'h0 |=> !reg_rdata[0])
    else $error("counter lsb set at fastest clock");
  a_gpio_when_off: assert property (!srst && en_reg == 8'h00 |=> first_port_pin_pair == $past(first_port_gpio)
    && second_port_pin_pair == $past(second_port_gpio))
    else $error("disabled pins differ from gpio");
  a_mask_gates: assert property (reg_wr && reg_addr == 8'h78 && !reg_wdata[0] |=> ##1 !pwm_irq)
    else $error("irq raised while masked");
  a_irq_and: assert property (pwm_irq |-> $past(mask_reg))
    else $error("irq without mask");
  a_flag_clear: assert property (reg_wr && reg_addr == 8'h78 && reg_wdata[1] ##2 reg_rd && reg_addr == 8'h78 |=> !reg_rdata[1])
    else $error("flag not cleared");
  a_duty_back: assert property (reg_wr && reg_addr == 8'h60 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h60 |=>
    reg_rdata == {6'h00, $past(reg_wdata[1:0], 3)})
    else $error("duty high byte readback wrong");
endmodule
bind hbp_pwm_timer hbp_pwm_timer_asserts u_asserts (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .first_port_gpio, .second_port_gpio, .first_port_pin_pair, .second_port_pin_pair, .pwm_irq);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] first_port_gpio = 8'h02;
  logic [7:0] second_port_gpio = 8'h00;
  logic [7:0] first_port_pin_pair;
  logic [7:0] second_port_pin_pair;
  logic pwm_irq;
  logic [7:0] coil_fwd;
  logic [7:0] coil_rev;
  int miscompares = 0;
  int checks_done = 0;
  int i;
  int n;
  logic [15:0] rv;
  logic [15:0] nl;
  logic [15:0] nr;
  logic [7:0] ra [6] = '{8'h78, 8'h79, 8'h7a, 8'h00, 8'h60, 8'h6f};
  logic [15:0] re [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h3, 16'hff};
  logic [7:0] tp [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [15:0] td [7] = '{16'h002, 16'h002, 16'h3fe, 16'h3ff, 16'h000, 16'h000, 16'h3fe};
  logic [15:0] tl [7] = '{16'h1fe, 16'h002, 16'h000, 16'h000, 16'h200, 16'h000, 16'h000};
  logic [15:0] tr [7] = '{16'h200, 16'h200, 16'h1fe, 16'h1ff, 16'h200, 16'h200, 16'h002};
  always #2 ref_clk = ~ref_clk;
  hbp_pwm_timer dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .first_port_gpio,
    .second_port_gpio, .first_port_pin_pair, .second_port_pin_pair, .pwm_irq);
  hbp_coil_model u_coil (.first_port_pin_pair, .second_port_pin_pair, .coil_fwd, .coil_rev);
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // strobes drop one edge before returning so no signal is driven twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    rv = {8'h00, reg_rdata};
  endtask
  // one full period at the fastest clock, phase does not matter
  task automatic span;
    nl = 16'h0;
    nr = 16'h0;
    repeat (512) begin
      @(posedge ref_clk);
      if (first_port_pin_pair[0] === 1'b1) nl++;
      if (first_port_pin_pair[1] === 1'b1) nr++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    wr(8'h00, 8'hff);
    for (i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(rv, re[i], re[i]);
    end
    wr(8'h60, 8'hfe);
    rd(8'h60);
    chk(rv, 16'h2, 16'h2);
    $display("test registers done");
    wr(8'h7c, 8'h5a);
    rd(8'h7c);
    chk(rv, 16'h0, 16'h2);
    reg_addr <= 8'h7b;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_addr <= 8'h7c;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    chk({8'h00, reg_rdata}, 16'h0, 16'h0);
    @(posedge ref_clk);
    chk({8'h00, reg_rdata}, 16'h2, 16'h2);
    rd(8'h7c);
    chk(rv, 16'h6, 16'h8);
    wr(8'h7c, 8'h00);
    repeat (520) @(posedge ref_clk);
    rd(8'h7b);
    chk(rv, 16'h0, 16'h0);
    rd(8'h7c);
    chk(rv, 16'ha, 16'hc);
    for (i = 1; i < 4; i++) begin
      wr(8'h78, {2'h0, i[1:0], 4'h0});
      // upper-byte write must clear the counter just as the lower one does
      wr(8'h7b, 8'h00);
      repeat (64) @(posedge ref_clk);
      rd(8'h7c);
      chk(rv, (16'h42 >> i) - 16'h1, (16'h42 >> i) + 16'h1);
    end
    wr(8'h78, 8'h00);
    $display("test counter done");
    wr(8'h79, 8'h01);
    for (i = 0; i < 7; i++) begin
      wr(8'h7a, tp[i]);
      wr(8'h60, td[i][15:8]);
      wr(8'h61, td[i][7:0]);
      wr(8'h7c, 8'h00);
      span;
      chk(nl, tl[i], tl[i]);
      chk(nr, tr[i], tr[i]);
    end
    wr(8'h7a, 8'h00);
    span;
    chk(nr, 16'h1fe, 16'h1fe);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h02);
    wr(8'h7c, 8'h00);
    wr(8'h61, 8'h80);
    repeat (20) @(posedge ref_clk);
    chk({15'h0, first_port_pin_pair[0]}, 16'h1, 16'h1);
    repeat (512) @(posedge ref_clk);
    chk({15'h0, first_port_pin_pair[0]}, 16'h0, 16'h0);
    wr(8'h79, 8'h00);
    // pins are registered, so the gpio level shows one edge after the enable drops
    @(posedge ref_clk);
    chk({8'h00, first_port_pin_pair}, 16'h2, 16'h2);
    chk({14'h0, coil_fwd[0], coil_rev[0]}, 16'h1, 16'h1);
    $display("test waveform done");
    wr(8'h78, 8'h01);
    wr(8'h7c, 8'h00);
    n = 0;
    while (pwm_irq !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n[15:0], 16'h7ff8, 16'h8008);
    if (n >= 40000) end_of_test;
    rd(8'h78);
    chk(rv, 16'h3, 16'h3);
    wr(8'h78, 8'h00);
    @(posedge ref_clk);
    chk({15'h0, pwm_irq}, 16'h0, 16'h0);
    wr(8'h78, 8'h03);
    rd(8'h78);
    chk(rv, 16'h1, 16'h1);
    chk({15'h0, pwm_irq}, 16'h0, 16'h0);
    wr(8'h78, 8'hff);
    rd(8'h78);
    chk(rv, 16'h31, 16'h31);
    $display("test interrupt done");
    end_of_test;
  end
endmodule
`default_nettype wire
